// >>> rtl/sdbcl_device.sv
`default_nettype none
module sdbcl_device #(
  parameter int BURST = sdbcl_pkg::BURST_LEN
) (
  input wire logic sys_clk,
  input wire logic nrst,
  sdbcl_if.dev lnk,
  output logic illegal_r,
  output logic [4*sdbcl_pkg::NUM_BANKS-1:0] bank_state_r,
  output logic [1:0] dev_state_r,
  output logic ready_r
);
  if (BURST < 1 || BURST > 255) begin : g_bad_burst // counters are CNT_W bits
    $error("burst length out of range");
  end

  // pins come from the far side: two flops before use
  logic [19:0] s1_r, s2_r;
  logic cke_prev_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 20'h0_0000;
      s2_r <= 20'h0_0000;
      cke_prev_r <= 1'b0;
    end else begin
      s1_r <= {lnk.cke, lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n, lnk.bank, lnk.addr};
      s2_r <= s1_r;
      cke_prev_r <= s2_r[19];
    end
  end

  logic cke, cs_n;
  logic [3:0] pins;
  logic [1:0] ba;
  logic ap;
  assign cke = s2_r[19];
  assign cs_n = s2_r[18];
  assign pins = {cs_n, s2_r[17:15]};
  assign ba = s2_r[14:13];
  assign ap = s2_r[sdbcl_pkg::AP_BIT];

  function automatic sdbcl_pkg::sdbcl_cmd_e decode(input logic [3:0] p);
    if (p[3]) return sdbcl_pkg::SDBCL_INHIBIT;
    case (p)
      sdbcl_pkg::PIN_NOP: return sdbcl_pkg::SDBCL_NOP;
      sdbcl_pkg::PIN_ACTIVE: return sdbcl_pkg::SDBCL_ACTIVE;
      sdbcl_pkg::PIN_READ: return sdbcl_pkg::SDBCL_READ;
      sdbcl_pkg::PIN_WRITE: return sdbcl_pkg::SDBCL_WRITE;
      sdbcl_pkg::PIN_PRECHARGE: return sdbcl_pkg::SDBCL_PRECHARGE;
      sdbcl_pkg::PIN_REFRESH: return sdbcl_pkg::SDBCL_REFRESH;
      sdbcl_pkg::PIN_MODE_LOAD: return sdbcl_pkg::SDBCL_MODE_LOAD;
      sdbcl_pkg::PIN_BURST_STOP: return sdbcl_pkg::SDBCL_BURST_STOP;
      default: return sdbcl_pkg::SDBCL_NOP;
    endcase
  endfunction

  // busy states a command to the same bank may not interrupt
  function automatic logic locked(input sdbcl_pkg::sdbcl_bank_e s);
    return s == sdbcl_pkg::SDBCL_B_ACTIVATING || s == sdbcl_pkg::SDBCL_B_PRECHARGING ||
           s == sdbcl_pkg::SDBCL_B_READ_AP || s == sdbcl_pkg::SDBCL_B_WRITE_AP ||
           s == sdbcl_pkg::SDBCL_B_WR_RECOVER;
  endfunction

  logic [sdbcl_pkg::CNT_W-1:0] dev_cnt_r, sr_cnt_r;
  sdbcl_pkg::sdbcl_cmd_e cmd;
  logic valid;
  assign cmd = decode(pins);
  // no legality checking around clock-enable transitions or self refresh exit
  assign valid = cke && cke_prev_r && (sr_cnt_r == '0);

  sdbcl_pkg::sdbcl_bank_e st_r [sdbcl_pkg::NUM_BANKS];
  logic [sdbcl_pkg::CNT_W-1:0] cnt_r [sdbcl_pkg::NUM_BANKS];
  logic [sdbcl_pkg::CNT_W-1:0] cut_r [sdbcl_pkg::NUM_BANKS];
  sdbcl_pkg::sdbcl_dev_e dev_r;
  logic [1:0] last_bank_r;
  logic last_valid_r;

  logic all_idle, any_locked, all_prechargeable;
  always_comb begin
    all_idle = 1'b1;
    any_locked = 1'b0;
    all_prechargeable = 1'b1;
    for (int i = 0; i < sdbcl_pkg::NUM_BANKS; i++) begin
      if (st_r[i] != sdbcl_pkg::SDBCL_B_IDLE) all_idle = 1'b0;
      if (locked(st_r[i]) && st_r[i] != sdbcl_pkg::SDBCL_B_PRECHARGING) begin
        all_prechargeable = 1'b0;
      end
    end
    any_locked = locked(st_r[ba]);
  end

  // legality of the command this edge
  logic bad;
  always_comb begin
    bad = 1'b0;
    if (valid && cmd != sdbcl_pkg::SDBCL_INHIBIT && cmd != sdbcl_pkg::SDBCL_NOP) begin
      if (dev_r != sdbcl_pkg::SDBCL_D_NONE) bad = 1'b1;
      else case (cmd)
        sdbcl_pkg::SDBCL_REFRESH, sdbcl_pkg::SDBCL_MODE_LOAD: bad = !all_idle;
        sdbcl_pkg::SDBCL_ACTIVE: bad = st_r[ba] != sdbcl_pkg::SDBCL_B_IDLE;
        sdbcl_pkg::SDBCL_READ, sdbcl_pkg::SDBCL_WRITE:
          bad = !(st_r[ba] == sdbcl_pkg::SDBCL_B_ACTIVE || st_r[ba] == sdbcl_pkg::SDBCL_B_READ ||
                  st_r[ba] == sdbcl_pkg::SDBCL_B_WRITE);
        sdbcl_pkg::SDBCL_PRECHARGE: bad = ap ? !all_prechargeable : any_locked;
        sdbcl_pkg::SDBCL_BURST_STOP: bad = !last_valid_r;
        default: bad = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) illegal_r <= 1'b0;
    else illegal_r <= bad;
  end

  logic is_rw, acc;
  assign acc = valid && !bad;
  assign is_rw = acc && (cmd == sdbcl_pkg::SDBCL_READ || cmd == sdbcl_pkg::SDBCL_WRITE);

  // most recent burst owner for burst stop
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      last_bank_r <= 2'h0;
      last_valid_r <= 1'b0;
    end else if (is_rw && !ap) begin
      last_bank_r <= ba;
      last_valid_r <= 1'b1;
    end else if (acc && (cmd == sdbcl_pkg::SDBCL_BURST_STOP ||
                 (cmd == sdbcl_pkg::SDBCL_PRECHARGE && (ap || ba == last_bank_r)))) begin
      last_valid_r <= 1'b0;
    end else if (last_valid_r && st_r[last_bank_r] != sdbcl_pkg::SDBCL_B_READ &&
                 st_r[last_bank_r] != sdbcl_pkg::SDBCL_B_WRITE) begin
      last_valid_r <= 1'b0;
    end
  end

  // device-wide busy tracker and self refresh exit hold-off
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dev_r <= sdbcl_pkg::SDBCL_D_NONE;
      dev_cnt_r <= '0;
      sr_cnt_r <= '0;
    end else begin
      if (cke && !cke_prev_r) sr_cnt_r <= sdbcl_pkg::CNT_W'(sdbcl_pkg::SR_EXIT_CYC);
      else if (sr_cnt_r != '0) sr_cnt_r <= sr_cnt_r - 1'b1;
      if (dev_r != sdbcl_pkg::SDBCL_D_NONE) begin
        if (dev_cnt_r <= 1) dev_r <= sdbcl_pkg::SDBCL_D_NONE;
        dev_cnt_r <= dev_cnt_r - 1'b1;
      end else if (acc && cmd == sdbcl_pkg::SDBCL_REFRESH) begin
        dev_r <= sdbcl_pkg::SDBCL_D_REFRESH;
        dev_cnt_r <= sdbcl_pkg::CNT_W'(sdbcl_pkg::REFRESH_CYC);
      end else if (acc && cmd == sdbcl_pkg::SDBCL_MODE_LOAD) begin
        dev_r <= sdbcl_pkg::SDBCL_D_MODE;
        dev_cnt_r <= sdbcl_pkg::CNT_W'(sdbcl_pkg::MODE_CYC);
      end else if (acc && cmd == sdbcl_pkg::SDBCL_PRECHARGE && ap) begin
        dev_r <= sdbcl_pkg::SDBCL_D_PRE_ALL;
        dev_cnt_r <= sdbcl_pkg::CNT_W'(sdbcl_pkg::PRECHARGE_CYC);
      end
    end
  end

  // per-bank state machines
  for (genvar b = 0; b < sdbcl_pkg::NUM_BANKS; b++) begin : g_bank
    logic mine, other_rw, pre_all;
    assign mine = acc && ba == 2'(b);
    assign other_rw = is_rw && ba != 2'(b);
    assign pre_all = acc && cmd == sdbcl_pkg::SDBCL_PRECHARGE && ap;
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        st_r[b] <= sdbcl_pkg::SDBCL_B_IDLE;
        cnt_r[b] <= '0;
        cut_r[b] <= '0;
      end else if (pre_all && st_r[b] != sdbcl_pkg::SDBCL_B_IDLE) begin
        st_r[b] <= sdbcl_pkg::SDBCL_B_PRECHARGING; // banks follow the device timer
        cnt_r[b] <= sdbcl_pkg::CNT_W'(sdbcl_pkg::PRECHARGE_CYC);
      end else begin
        if (cut_r[b] != '0) cut_r[b] <= cut_r[b] - 1'b1;
        if (cnt_r[b] != '0) cnt_r[b] <= cnt_r[b] - 1'b1;
        case (st_r[b])
          sdbcl_pkg::SDBCL_B_IDLE: begin
            if (mine && cmd == sdbcl_pkg::SDBCL_ACTIVE) begin
              st_r[b] <= sdbcl_pkg::SDBCL_B_ACTIVATING;
              cnt_r[b] <= sdbcl_pkg::CNT_W'(sdbcl_pkg::ACT_CYC);
            end // precharge here is a nop
          end
          sdbcl_pkg::SDBCL_B_ACTIVATING:
            if (cnt_r[b] <= 1) st_r[b] <= sdbcl_pkg::SDBCL_B_ACTIVE;
          sdbcl_pkg::SDBCL_B_ACTIVE, sdbcl_pkg::SDBCL_B_READ, sdbcl_pkg::SDBCL_B_WRITE: begin
            if (mine && cmd == sdbcl_pkg::SDBCL_READ) begin
              st_r[b] <= ap ? sdbcl_pkg::SDBCL_B_READ_AP : sdbcl_pkg::SDBCL_B_READ;
              cnt_r[b] <= sdbcl_pkg::CNT_W'(BURST);
            end else if (mine && cmd == sdbcl_pkg::SDBCL_WRITE) begin
              st_r[b] <= ap ? sdbcl_pkg::SDBCL_B_WRITE_AP : sdbcl_pkg::SDBCL_B_WRITE;
              cnt_r[b] <= sdbcl_pkg::CNT_W'(BURST);
            end else if (mine && cmd == sdbcl_pkg::SDBCL_PRECHARGE) begin
              st_r[b] <= sdbcl_pkg::SDBCL_B_PRECHARGING;
              cnt_r[b] <= sdbcl_pkg::CNT_W'(sdbcl_pkg::PRECHARGE_CYC);
            end else if (acc && cmd == sdbcl_pkg::SDBCL_BURST_STOP && last_bank_r == 2'(b) &&
                         st_r[b] != sdbcl_pkg::SDBCL_B_ACTIVE) begin
              st_r[b] <= sdbcl_pkg::SDBCL_B_ACTIVE;
            end else if (st_r[b] == sdbcl_pkg::SDBCL_B_READ && other_rw &&
                         cmd == sdbcl_pkg::SDBCL_READ) begin
              cut_r[b] <= sdbcl_pkg::CNT_W'(sdbcl_pkg::READ_LATENCY);
            end else if (st_r[b] != sdbcl_pkg::SDBCL_B_ACTIVE && other_rw) begin
              st_r[b] <= sdbcl_pkg::SDBCL_B_ACTIVE;
            end else if (cut_r[b] == 1 && st_r[b] == sdbcl_pkg::SDBCL_B_READ) begin
              st_r[b] <= sdbcl_pkg::SDBCL_B_ACTIVE;
            end else if (st_r[b] != sdbcl_pkg::SDBCL_B_ACTIVE && cnt_r[b] == 1) begin
              st_r[b] <= sdbcl_pkg::SDBCL_B_ACTIVE; // burst done
            end
          end
          sdbcl_pkg::SDBCL_B_READ_AP: begin
            if (other_rw || cnt_r[b] <= 1) begin
              st_r[b] <= sdbcl_pkg::SDBCL_B_PRECHARGING;
              cnt_r[b] <= sdbcl_pkg::CNT_W'(sdbcl_pkg::PRECHARGE_CYC);
            end
          end
          sdbcl_pkg::SDBCL_B_WRITE_AP: begin
            if (other_rw || cnt_r[b] <= 1) begin
              st_r[b] <= sdbcl_pkg::SDBCL_B_WR_RECOVER;
              cnt_r[b] <= sdbcl_pkg::CNT_W'(sdbcl_pkg::WR_REC_CYC);
            end
          end
          sdbcl_pkg::SDBCL_B_WR_RECOVER: begin
            if (cnt_r[b] <= 1) begin
              st_r[b] <= sdbcl_pkg::SDBCL_B_PRECHARGING;
              cnt_r[b] <= sdbcl_pkg::CNT_W'(sdbcl_pkg::PRECHARGE_CYC);
            end
          end
          sdbcl_pkg::SDBCL_B_PRECHARGING:
            if (cnt_r[b] <= 1) st_r[b] <= sdbcl_pkg::SDBCL_B_IDLE;
          default: st_r[b] <= sdbcl_pkg::SDBCL_B_IDLE;
        endcase
      end
    end
  end

  // status outputs, registered
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bank_state_r <= '0;
      dev_state_r <= 2'h0;
      ready_r <= 1'b0;
    end else begin
      for (int i = 0; i < sdbcl_pkg::NUM_BANKS; i++) bank_state_r[4*i +: 4] <= st_r[i];
      dev_state_r <= dev_r;
      ready_r <= valid && dev_r == sdbcl_pkg::SDBCL_D_NONE;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/sdbcl_pkg.sv
`default_nettype none
package sdbcl_pkg;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int CNT_W = 8;
  localparam int BURST_LEN = 4;
  localparam int CLK_PERIOD_NS = 8;
  // times in ns as printed defaults, read latency in cycles; cycles derived, least times rounded up
  localparam int PRECHARGE_TIME_NS = 20;
  localparam int ACTIVATE_TO_ACCESS_TIME_NS = 20;
  localparam int REFRESH_CYCLE_TIME_NS = 66;
  localparam int MODE_LOAD_TIME_NS = 16;
  localparam int WRITE_RECOVERY_TIME_NS = 16;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 75;
  localparam int READ_LATENCY = 3;
  localparam int PRECHARGE_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACT_CYC = (ACTIVATE_TO_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYC = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MODE_CYC = (MODE_LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_REC_CYC = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SR_EXIT_CYC = (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // commands as decoded from cs_n, ras_n, cas_n, we_n
  typedef enum logic [3:0] {
    SDBCL_INHIBIT, SDBCL_NOP, SDBCL_ACTIVE, SDBCL_READ, SDBCL_WRITE,
    SDBCL_PRECHARGE, SDBCL_REFRESH, SDBCL_MODE_LOAD, SDBCL_BURST_STOP
  } sdbcl_cmd_e;

  // per-bank state
  typedef enum logic [3:0] {
    SDBCL_B_IDLE, SDBCL_B_ACTIVATING, SDBCL_B_ACTIVE, SDBCL_B_READ, SDBCL_B_WRITE,
    SDBCL_B_READ_AP, SDBCL_B_WRITE_AP, SDBCL_B_WR_RECOVER, SDBCL_B_PRECHARGING
  } sdbcl_bank_e;

  typedef enum logic [1:0] {
    SDBCL_D_NONE, SDBCL_D_REFRESH, SDBCL_D_MODE, SDBCL_D_PRE_ALL
  } sdbcl_dev_e;

  localparam logic [3:0] PIN_INHIBIT = 4'h8;
  localparam logic [3:0] PIN_NOP = 4'h7;
  localparam logic [3:0] PIN_ACTIVE = 4'h3;
  localparam logic [3:0] PIN_READ = 4'h5;
  localparam logic [3:0] PIN_WRITE = 4'h4;
  localparam logic [3:0] PIN_PRECHARGE = 4'h2;
  localparam logic [3:0] PIN_REFRESH = 4'h1;
  localparam logic [3:0] PIN_MODE_LOAD = 4'h0;
  localparam logic [3:0] PIN_BURST_STOP = 4'h6;
  localparam int AP_BIT = 10;
  localparam int ADDR_W = 13;
endpackage
`default_nettype wire

// >>> rtl/sdbcl_if.sv
`default_nettype none
// command link between controller and the legality-tracking device end
interface sdbcl_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] bank;
  logic [12:0] addr;
  logic data_mask;
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank, addr, data_mask);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, bank, addr, data_mask);
endinterface
`default_nettype wire

// >>> rtl/sdbcl_ctrl.sv
`default_nettype none
// controller end: drives one request per command with a nop after each, holds off only the refresh, mode load and precharge-all windows
module sdbcl_ctrl (
  input wire logic sys_clk,
  input wire logic nrst,
  sdbcl_if.ctrl lnk,
  input wire logic req_valid,
  input wire logic [3:0] req_pins,
  input wire logic [1:0] req_bank,
  input wire logic [12:0] req_addr,
  input wire logic req_mask,
  output logic req_ready_r
);
  // device-wide hold-off so nothing executable lands in busy windows
  logic [sdbcl_pkg::CNT_W-1:0] hold_r;
  logic take;
  assign take = req_valid && req_ready_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hold_r <= '0;
      req_ready_r <= 1'b0;
    end else begin
      if (take && req_pins == sdbcl_pkg::PIN_REFRESH) begin
        hold_r <= sdbcl_pkg::CNT_W'(sdbcl_pkg::REFRESH_CYC);
      end else if (take && req_pins == sdbcl_pkg::PIN_MODE_LOAD) begin
        hold_r <= sdbcl_pkg::CNT_W'(sdbcl_pkg::MODE_CYC);
      end else if (take && req_pins == sdbcl_pkg::PIN_PRECHARGE && req_addr[sdbcl_pkg::AP_BIT]) begin
        hold_r <= sdbcl_pkg::CNT_W'(sdbcl_pkg::PRECHARGE_CYC);
      end else if (hold_r != '0) hold_r <= hold_r - 1'b1;
      req_ready_r <= !take && hold_r <= 1;
    end
  end

  // pins: nop unless a request is taken; cke held high
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lnk.cke <= 1'b0;
      {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n} <= sdbcl_pkg::PIN_INHIBIT;
      lnk.bank <= 2'h0;
      lnk.addr <= '0;
      lnk.data_mask <= 1'b0;
    end else begin
      lnk.cke <= 1'b1;
      {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n} <= take ? req_pins : sdbcl_pkg::PIN_NOP;
      lnk.bank <= req_bank;
      lnk.addr <= req_addr;
      lnk.data_mask <= req_mask; // user sets mask ahead of write
    end
  end
endmodule
`default_nettype wire

// >>> bench/sdbcl_chk_sva.sv
`default_nettype none
// link-side checks on what the controller end puts on the wire
module sdbcl_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank,
  input wire logic [12:0] addr,
  input wire logic data_mask
);
  logic exec;
  logic [1:0] kind;
  logic [1:0] last_k_r;
  logic [7:0] gap_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // selected and not a nop; kind marks the device-wide busy commands
  assign exec = !cs_n && !(ras_n && cas_n && we_n);
  assign kind = ({cs_n, ras_n, cas_n, we_n} == sdbcl_pkg::PIN_REFRESH) ? 2'h1 :
                ({cs_n, ras_n, cas_n, we_n} == sdbcl_pkg::PIN_MODE_LOAD) ? 2'h2 :
                ({cs_n, ras_n, cas_n, we_n} == sdbcl_pkg::PIN_PRECHARGE && addr[10]) ? 2'h3 :
                2'h0;
  // distance since last command; saturates so long idles never wrap to a false gap
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      last_k_r <= 2'h0;
      gap_r <= 8'h00;
    end else if (exec) begin
      last_k_r <= kind;
      gap_r <= 8'h01;
    end else if (gap_r != 8'hff) begin
      gap_r <= gap_r + 8'h01;
    end
  end
  property p_cke_wake; !cke |=> cke; endproperty
  property p_cke_hold; cke |=> cke; endproperty
  property p_inhibit_low; !cke |-> cs_n; endproperty
  property p_wake_nop; $rose(cke) |-> !cs_n && ras_n && cas_n && we_n; endproperty
  property p_one_cycle; exec |=> !cs_n && ras_n && cas_n && we_n; endproperty
  property p_ref_gap; exec && last_k_r == 2'h1 |-> gap_r >= 8'(sdbcl_pkg::REFRESH_CYC); endproperty
  property p_mode_gap; exec && last_k_r == 2'h2 |-> gap_r >= 8'(sdbcl_pkg::MODE_CYC); endproperty
  property p_pall_gap; exec && last_k_r == 2'h3 |-> gap_r >= 8'(sdbcl_pkg::PRECHARGE_CYC); endproperty
  a_cke_wake: assert property (p_cke_wake)
    else $error("clock enable not raised after reset");
  a_cke_hold: assert property (p_cke_hold)
    else $error("clock enable dropped");
  a_inhibit_low: assert property (p_inhibit_low)
    else $error("command driven with clock enable low");
  a_wake_nop: assert property (p_wake_nop)
    else $error("no nop when clock enable rises");
  a_one_cycle: assert property (p_one_cycle)
    else $error("command not followed by nop");
  a_ref_gap: assert property (p_ref_gap)
    else $error("command inside refresh window");
  a_mode_gap: assert property (p_mode_gap)
    else $error("command inside mode load window");
  a_pall_gap: assert property (p_pall_gap)
    else $error("command inside precharge-all window");
  c_ref: cover property (exec && kind == 2'h1);
  c_mode: cover property (exec && kind == 2'h2);
  c_pall: cover property (exec && kind == 2'h3);
  c_mask_wr: cover property (data_mask ##1 (exec && {cs_n, ras_n, cas_n, we_n} == sdbcl_pkg::PIN_WRITE));
endmodule
`default_nettype wire

// >>> bench/test_sdram_bank_command_legality.sv
`default_nettype none
module test_sdram_bank_command_legality;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] P_ACT = sdbcl_pkg::PIN_ACTIVE;
  localparam logic [3:0] P_RD = sdbcl_pkg::PIN_READ;
  localparam logic [3:0] P_WR = sdbcl_pkg::PIN_WRITE;
  localparam logic [3:0] P_PRE = sdbcl_pkg::PIN_PRECHARGE;
  logic sys_clk, nrst, req_valid, req_mask, req_ready_r, illegal_r, ready_r;
  logic [3:0] req_pins;
  logic [1:0] req_bank, dev_state_r;
  logic [12:0] req_addr;
  logic [15:0] bank_state_r;
  logic [31:0] tr [4];
  logic [31:0] dtr;
  logic [3:0] lst [4];
  logic [1:0] dl;
  int n_fail, cmp_count, n_ill, i;
  int seed;
  sdbcl_if lnk_if ();
  sdbcl_ctrl i_sdbcl_ctrl (.sys_clk(sys_clk), .nrst(nrst), .lnk(lnk_if), .req_valid(req_valid),
    .req_pins(req_pins), .req_bank(req_bank), .req_addr(req_addr), .req_mask(req_mask),
    .req_ready_r(req_ready_r));
  // longer bursts so other-bank interrupts land before the natural end
  sdbcl_device #(.BURST(8)) i_sdbcl_device (.sys_clk(sys_clk), .nrst(nrst), .lnk(lnk_if),
    .illegal_r(illegal_r), .bank_state_r(bank_state_r), .dev_state_r(dev_state_r),
    .ready_r(ready_r));
  sdbcl_chk i_sdbcl_chk (.sys_clk(sys_clk), .nrst(nrst), .cke(lnk_if.cke), .cs_n(lnk_if.cs_n),
    .ras_n(lnk_if.ras_n), .cas_n(lnk_if.cas_n), .we_n(lnk_if.we_n), .bank(lnk_if.bank),
    .addr(lnk_if.addr), .data_mask(lnk_if.data_mask));
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // model side: trail of distinct states per bank, timing-tolerant but order-exact
  always @(negedge sys_clk) begin
    if (nrst === 1'b1) begin
      for (int b = 0; b < 4; b++) begin
        if (bank_state_r[4*b+:4] !== lst[b]) begin
          tr[b] = {tr[b][27:0], bank_state_r[4*b+:4]};
          lst[b] = bank_state_r[4*b+:4];
        end
      end
      if (dev_state_r !== dl) begin
        dtr = {dtr[27:0], 2'b00, dev_state_r};
        dl = dev_state_r;
      end
      if (illegal_r === 1'b1) n_ill++;
    end
  end
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  // one request; held until the edge where ready is sampled high
  task automatic issue(input logic [3:0] p, input logic [1:0] b, input logic ap);
    logic [31:0] r;
    int k;
    r = $random(seed);
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_pins = p;
    req_bank = b;
    req_addr = r[12:0];
    req_addr[10] = ap;
    req_mask = r[13];
    // ready is a flop: its level at this falling edge is what the next rising edge takes
    k = 0;
    while (req_ready_r !== 1'b1 && k < 100) begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= 100) begin
      n_fail++;
      $display("[FAIL] %0t request never taken", $time);
      wrap_up();
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
  endtask
  task automatic clr();
    for (int b = 0; b < 4; b++) tr[b] = 32'h0;
    dtr = 32'h0;
    n_ill = 0;
  endtask
  task automatic expect_all(input logic [31:0] t0, t1, t2, t3, td, input int ill);
    repeat (30) @(negedge sys_clk);
    chk(tr[0], t0);
    chk(tr[1], t1);
    chk(tr[2], t2);
    chk(tr[3], t3);
    chk(dtr, td);
    chk(32'(n_ill), 32'(ill));
    clr();
  endtask
  // main sequence
  initial begin
    seed = 32'h0288d4c4;
    nrst = 1'b0;
    req_valid = 1'b0;
    req_pins = sdbcl_pkg::PIN_NOP;
    req_bank = 2'h0;
    req_addr = 13'h0000;
    req_mask = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    dl = 2'h0;
    for (int b = 0; b < 4; b++) lst[b] = 4'h0;
    clr();
    repeat (6) @(negedge sys_clk);
    chk(32'({illegal_r, bank_state_r, dev_state_r, ready_r}), 32'h0000_0000);
    nrst = 1'b1;
    i = 0;
    while (ready_r !== 1'b1 && i < 200) begin
      @(negedge sys_clk);
      i++;
    end
    chk(32'(i >= sdbcl_pkg::SR_EXIT_CYC && i < 200), 32'h0000_0001);
    if (i >= 200) wrap_up();
    issue(P_PRE, 2'h0, 1'b0);
    issue(P_RD, 2'h1, 1'b0);
    expect_all(0, 0, 0, 0, 0, 1);
    issue(P_ACT, 2'h0, 1'b0);
    issue(P_ACT, 2'h0, 1'b0);
    for (int b = 1; b < 4; b++) issue(P_ACT, 2'(b), 1'b0);
    expect_all(32'h12, 32'h12, 32'h12, 32'h12, 0, 1);
    issue(P_RD, 2'h0, 1'b0);
    issue(P_PRE, 2'h3, 1'b0);
    issue(P_RD, 2'h1, 1'b0);
    expect_all(32'h32, 32'h32, 0, 32'h80, 0, 0);
    issue(P_ACT, 2'h3, 1'b0);
    repeat (10) @(negedge sys_clk);
    issue(P_WR, 2'h2, 1'b1);
    issue(P_WR, 2'h3, 1'b0);
    issue(sdbcl_pkg::PIN_BURST_STOP, 2'h0, 1'b0);
    expect_all(0, 0, 32'h6780, 32'h1242, 0, 0);
    issue(P_RD, 2'h0, 1'b1);
    issue(P_WR, 2'h1, 1'b0);
    expect_all(32'h580, 32'h42, 0, 0, 0, 0);
    issue(sdbcl_pkg::PIN_REFRESH, 2'h0, 1'b0);
    issue(P_PRE, 2'h2, 1'b1);
    expect_all(0, 32'h80, 0, 32'h80, 32'h30, 1);
    issue(sdbcl_pkg::PIN_REFRESH, 2'h0, 1'b0);
    issue(sdbcl_pkg::PIN_MODE_LOAD, 2'h0, 1'b0);
    expect_all(0, 0, 0, 0, 32'h1020, 0);
    wrap_up();
  end
endmodule
`default_nettype wire
